// ===== usart_core.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module usart_core (
    input  wire logic                          i_clock,
    input  wire logic                          i_resetn,
    input  wire logic [usart_pkg::ADDR_W-1:0]  i_awaddr,
    input  wire logic                          i_awvalid,
    output logic                               o_awready,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic [3:0]                    i_wstrb,
    input  wire logic                          i_wvalid,
    output logic                               o_wready,
    output logic [1:0]                         o_bresp,
    output logic                               o_bvalid,
    input  wire logic                          i_bready,
    input  wire logic [usart_pkg::ADDR_W-1:0]  i_araddr,
    input  wire logic                          i_arvalid,
    output logic                               o_arready,
    output logic [31:0]                        o_rdata,
    output logic [1:0]                         o_rresp,
    output logic                               o_rvalid,
    input  wire logic                          i_rready,
    input  wire logic                          i_sleep,
    input  wire logic                          i_receive_data_pin,
    output logic                               o_receive_data_pin_out,
    output logic                               o_receive_data_pin_oe,
    output logic                               o_transmit_clock_pin_out,
    output logic                               o_transmit_clock_pin_oe,
    output logic                               o_start_bit,
    output logic                               o_wake
);
    import usart_pkg::*;

    baud_if b ();

    baud_gen u_baud (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .b        (b)
    );

    logic [CONTROL_W-1:0] ctl_q;
    logic [15:0]          divisor_q;
    logic                 rif_q;
    logic                 ovf_q;
    logic                 rx_idle_q;
    logic                 rx_meta_q;
    logic                 rx_sync_q;
    logic                 rx_prev_q;
    logic                 rx_fall;
    logic                 rx_rise;
    autobaud_state_t      ab_state_q;
    logic [15:0]          ab_count_q;
    logic [2:0]           ab_rises_q;
    logic                 ab_overflow;
    logic                 ab_fifth;
    logic                 ab_abort;
    logic                 wake_active;
    logic                 wake_seen_q;
    logic                 wake_fire;
    logic                 wake_end;
    logic                 master;
    logic                 tx_mode;
    logic [8:0]           tx_buf_q;
    logic                 tx_full_q;
    logic [8:0]           shift_q;
    logic [3:0]           bits_left_q;
    logic                 half_q;
    logic                 clk_active_q;
    logic                 data_q;
    logic                 load;
    logic                 start_q;
    logic                 wake_q;
    logic [ADDR_W-1:0]    awaddr_q;
    logic                 aw_have_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 w_have_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;
    logic                 do_write;
    logic                 ar_take;
    logic                 rx_read;
    logic [15:0]          wmask;
    logic [15:0]          wval;

    // ========================================
    // bus slave: address and data taken in either order
    assign o_awready = !aw_have_q && !bvalid_q;
    assign o_wready  = !w_have_q && !bvalid_q;
    assign do_write  = aw_have_q && w_have_q && !bvalid_q;
    assign o_arready = !rvalid_q;
    assign ar_take   = i_arvalid && !rvalid_q;
    assign rx_read   = ar_take && (i_araddr == OFF_RX_DATA);
    assign wmask     = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wval      = wdata_q[15:0] & wmask;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
            w_have_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (awaddr_q == OFF_CONTROL || awaddr_q == OFF_STATUS ||
                              awaddr_q == OFF_BAUD || awaddr_q == OFF_TX_DATA) ?
                             RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;

    // the shift register and transmit buffer have no read address; only their empty flags are visible
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (i_araddr)
                OFF_CONTROL: rdata_q <= {21'h0, ctl_q};
                OFF_STATUS:  rdata_q <= {27'h0, (bits_left_q == 4'h0), !tx_full_q,
                                         rif_q, rx_idle_q, ovf_q};
                OFF_BAUD:    rdata_q <= {16'h0000, divisor_q};
                OFF_RX_DATA: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;

    // ========================================
    // receive line synchroniser and edges
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= i_receive_data_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    assign rx_fall = rx_prev_q && !rx_sync_q;
    assign rx_rise = !rx_prev_q && rx_sync_q;

    // ========================================
    // control register; hardware clears the self-clearing enables
    assign wake_active = ctl_q[CTL_WAKE_ENABLE] && ctl_q[CTL_PORT_ENABLE] &&
                         !ctl_q[CTL_SYNC_MODE];
    assign wake_fire   = wake_active && !wake_seen_q && rx_fall;
    assign wake_end    = wake_seen_q && rx_rise;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_q <= CONTROL_RESET;
        end else if (do_write && awaddr_q == OFF_CONTROL) begin
            ctl_q <= (ctl_q & ~wmask[CONTROL_W-1:0]) | wval[CONTROL_W-1:0];
        end else begin
            if (wake_end) begin
                ctl_q[CTL_WAKE_ENABLE] <= 1'b0;
            end
            if (ab_fifth) begin
                ctl_q[CTL_AUTOBAUD_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_seen_q <= 1'b0;
            wake_q      <= 1'b0;
        end else begin
            wake_q <= wake_fire;
            if (!wake_active || wake_end) begin
                wake_seen_q <= 1'b0;
            end else if (wake_fire) begin
                wake_seen_q <= 1'b1;
            end
        end
    end

    assign o_wake = wake_q;

    // ========================================
    // auto-baud measurement, count held while asleep
    assign ab_abort    = !ctl_q[CTL_AUTOBAUD_EN] || !ctl_q[CTL_PORT_ENABLE];
    assign ab_overflow = (ab_state_q == AB_COUNT) && !i_sleep && (ab_count_q == COUNT_MAX);
    assign ab_fifth    = (ab_state_q == AB_COUNT) && !ab_abort && rx_rise &&
                         (ab_rises_q == LAST_RISE_INDEX);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ab_state_q <= AB_IDLE;
            ab_count_q <= 16'h0000;
            ab_rises_q <= 3'h0;
        end else if (ab_abort || wake_active) begin
            ab_state_q <= AB_IDLE;
        end else begin
            unique case (ab_state_q)
                AB_IDLE: ab_state_q <= AB_WAIT_FALL;
                AB_WAIT_FALL: begin
                    if (rx_fall) begin
                        ab_state_q <= AB_WAIT_RISE;
                    end
                end
                AB_WAIT_RISE: begin
                    if (rx_rise) begin
                        ab_state_q <= AB_COUNT;
                        ab_count_q <= 16'h0000;
                        ab_rises_q <= 3'h1;
                    end
                end
                AB_COUNT: begin
                    if (!i_sleep) begin
                        ab_count_q <= ab_count_q + 16'h0001;
                    end
                    if (ab_fifth) begin
                        ab_state_q <= AB_IDLE;
                    end else if (rx_rise) begin
                        ab_rises_q <= ab_rises_q + 3'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            divisor_q <= BAUD_RESET;
        end else if (do_write && awaddr_q == OFF_BAUD) begin
            divisor_q <= (divisor_q & ~wmask) | wval;
        end else if (ab_fifth && !ovf_q) begin
            divisor_q <= ab_count_q >> RATE_SHIFT;
        end
    end

    // ========================================
    // flags: a set in the same cycle as a clear wins
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rif_q     <= 1'b0;
            ovf_q     <= 1'b0;
            rx_idle_q <= 1'b1;
        end else begin
            if (ab_overflow || ab_fifth || wake_fire) begin
                rif_q <= 1'b1;
            end else if (rx_read) begin
                rif_q <= 1'b0;
            end
            if (ab_overflow) begin
                ovf_q <= 1'b1;
            end else if (do_write && awaddr_q == OFF_STATUS && wstrb_q[0] &&
                         wdata_q[ST_OVERFLOW]) begin
                ovf_q <= 1'b0;
            end
            if (ab_fifth || ab_state_q == AB_IDLE) begin
                rx_idle_q <= 1'b1;
            end else if (ab_state_q == AB_WAIT_RISE || ab_state_q == AB_COUNT) begin
                rx_idle_q <= 1'b0;
            end
        end
    end

    // falling edges in async mode while awake, outside auto-baud and wake, are start bits
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= rx_fall && ctl_q[CTL_PORT_ENABLE] && !ctl_q[CTL_SYNC_MODE] &&
                       !ctl_q[CTL_WAKE_ENABLE] && !i_sleep && ab_abort;
        end
    end

    assign o_start_bit = start_q;

    // ========================================
    // synchronous master transmit
    assign master  = ctl_q[CTL_PORT_ENABLE] && ctl_q[CTL_SYNC_MODE] && ctl_q[CTL_CLOCK_MASTER];
    assign tx_mode = master && !ctl_q[CTL_SINGLE_RX] && !ctl_q[CTL_CONT_RX] &&
                     ctl_q[CTL_TX_ENABLE];
    assign load    = tx_mode && tx_full_q && (bits_left_q == 4'h0);
    assign b.divisor = divisor_q;
    assign b.run     = ctl_q[CTL_PORT_ENABLE] && !i_sleep;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_buf_q  <= 9'h000;
            tx_full_q <= 1'b0;
        end else if (!ctl_q[CTL_PORT_ENABLE]) begin
            tx_full_q <= 1'b0;
        end else if (do_write && awaddr_q == OFF_TX_DATA && wstrb_q[0] && !tx_full_q) begin
            tx_buf_q  <= {ctl_q[CTL_NINTH_BIT], wdata_q[7:0]};
            tx_full_q <= 1'b1;
        end else if (load) begin
            tx_full_q <= 1'b0;
        end
    end

    // two baud ticks form one clock cycle; no start or stop bits are framed
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_q      <= 9'h000;
            bits_left_q  <= 4'h0;
            half_q       <= 1'b0;
            clk_active_q <= 1'b0;
            data_q       <= 1'b0;
        end else if (!tx_mode) begin
            bits_left_q  <= 4'h0;
            half_q       <= 1'b0;
            clk_active_q <= 1'b0;
        end else if (load) begin
            shift_q     <= tx_buf_q;
            bits_left_q <= ctl_q[CTL_NINE_BIT] ? BITS_NINE : BITS_EIGHT;
        end else if (b.tick && bits_left_q != 4'h0) begin
            if (!half_q) begin
                data_q       <= shift_q[0];
                shift_q      <= shift_q >> 1;
                clk_active_q <= 1'b1;
                half_q       <= 1'b1;
            end else begin
                clk_active_q <= 1'b0;
                half_q       <= 1'b0;
                bits_left_q  <= bits_left_q - 4'h1;
            end
        end
    end

    assign o_transmit_clock_pin_out = ctl_q[CTL_CLOCK_POL] ^ clk_active_q;
    assign o_transmit_clock_pin_oe  = master;
    assign o_receive_data_pin_out   = data_q;
    assign o_receive_data_pin_oe    = tx_mode;

    // ========================================
    // checks
    a_overflow_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ab_overflow |=> ovf_q) else $error("overflow flag not set");
    a_overflow_rx_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ab_overflow |=> rif_q) else $error("receive flag not set on overflow");
    a_idle_while_count: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (ab_state_q == AB_COUNT) ##1 (ab_state_q == AB_COUNT) |-> !rx_idle_q)
        else $error("receiver idle high during measurement");
    a_fifth_rise_flags: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ab_fifth && !do_write |=> rif_q && rx_idle_q && !ctl_q[CTL_AUTOBAUD_EN])
        else $error("fifth rise did not set flags");
    a_sleep_stops_baud: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_sleep |=> !b.tick) else $error("baud tick while asleep");
    a_wake_async_only: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(wake_seen_q) |-> !$past(ctl_q[CTL_SYNC_MODE]))
        else $error("wake armed in sync mode");
    a_wake_no_start: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ctl_q[CTL_WAKE_ENABLE] |=> !o_start_bit) else $error("start bit while wake enabled");
    a_wake_sets_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
        wake_fire |=> rif_q && o_wake) else $error("wake event lost");
    a_wake_self_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
        wake_end && !do_write |=> !ctl_q[CTL_WAKE_ENABLE]) else $error("wake enable stuck");
    a_data_stable: assert property (@(posedge i_clock) disable iff (!i_resetn)
        half_q && $past(half_q) |-> $stable(o_receive_data_pin_out))
        else $error("data moved inside a clock cycle");
    a_clock_idle: assert property (@(posedge i_clock) disable iff (!i_resetn)
        bits_left_q == 4'h0 |-> o_transmit_clock_pin_out == ctl_q[CTL_CLOCK_POL])
        else $error("clock not at idle level");
endmodule

// ===== usart_pkg.sv
package usart_pkg;
    // ========================================
    // register map (byte addresses)
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  OFF_CONTROL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS       = 8'h04;
    localparam logic [7:0]  OFF_BAUD         = 8'h08;
    localparam logic [7:0]  OFF_TX_DATA      = 8'h0c;
    localparam logic [7:0]  OFF_RX_DATA      = 8'h10;
    // ========================================
    // control register fields
    localparam int          CTL_PORT_ENABLE  = 0;
    localparam int          CTL_SYNC_MODE    = 1;
    localparam int          CTL_CLOCK_MASTER = 2;
    localparam int          CTL_SINGLE_RX    = 3;
    localparam int          CTL_CONT_RX      = 4;
    localparam int          CTL_TX_ENABLE    = 5;
    localparam int          CTL_NINE_BIT     = 6;
    localparam int          CTL_NINTH_BIT    = 7;
    localparam int          CTL_CLOCK_POL    = 8;
    localparam int          CTL_WAKE_ENABLE  = 9;
    localparam int          CTL_AUTOBAUD_EN  = 10;
    localparam int          CONTROL_W        = 11;
    localparam logic [10:0] CONTROL_RESET    = 11'h000;
    // ========================================
    // status register fields
    localparam int          ST_OVERFLOW      = 0;
    localparam int          ST_RX_IDLE       = 1;
    localparam int          ST_RX_FLAG       = 2;
    localparam int          ST_TX_BUF_EMPTY  = 3;
    localparam int          ST_SHIFT_EMPTY   = 4;
    // ========================================
    // reset values and counts
    localparam logic [15:0] BAUD_RESET       = 16'h0000;
    localparam logic [15:0] COUNT_MAX        = 16'hffff;
    localparam logic [2:0]  LAST_RISE_INDEX  = 3'h4;
    localparam int          RATE_SHIFT       = 3;
    localparam logic [3:0]  BITS_EIGHT       = 4'h8;
    localparam logic [3:0]  BITS_NINE        = 4'h9;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    typedef enum logic [1:0] {AB_IDLE, AB_WAIT_FALL, AB_WAIT_RISE, AB_COUNT} autobaud_state_t;
endpackage

// ===== baud_if.sv
`timescale 1ns/10ps
interface baud_if;
    logic [15:0] divisor;
    logic        run;
    logic        tick;
    modport gen  (input divisor, input run, output tick);
    modport user (output divisor, output run, input tick);
endinterface

// ===== baud_gen.sv
`timescale 1ns/10ps
module baud_gen (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    baud_if.gen       b
);
    import usart_pkg::*;

    logic [15:0] count_q;
    logic        tick_q;

    // ========================================
    // one tick every divisor+1 clocks while running
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else if (!b.run) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else if (count_q >= b.divisor) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
            tick_q  <= 1'b0;
        end
    end

    assign b.tick = tick_q;
endmodule

// ===== usart_far_end.sv
`timescale 1ns/10ps
// ========================================
// far side: sync slave capture and async line driver
module usart_far_end (
    input  wire logic i_clock,
    input  wire logic i_pol,
    input  wire logic i_sck,
    input  wire logic i_sda,
    output logic      o_line
);
    logic       sck_q   = 1'b0;
    logic [8:0] shift_q = 9'h000;
    int         bits_q  = 0;
    initial o_line = 1'b1;
    // slave takes each bit as the clock returns to idle
    always @(posedge i_clock) begin
        sck_q <= i_sck;
        if (sck_q != i_pol && i_sck == i_pol) begin
            shift_q <= {i_sda, shift_q[8:1]};
            bits_q  <= bits_q + 1;
        end
    end
    // low for n bit times of 16 clocks, then one bit time high
    task automatic send(input int n);
        o_line <= 1'b0;
        repeat (n * 16) @(posedge i_clock);
        o_line <= 1'b1;
        repeat (16) @(posedge i_clock);
    endtask
endmodule

// ===== usart_autobaud_wake_sync_master_tx_test.sv
`timescale 1ns/10ps
module usart_autobaud_wake_sync_master_tx_test;
    import usart_pkg::*;
    logic        clk, rstn, awvalid, wvalid, arvalid, sleep, pol, line, pin, wk;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, d_out, d_oe, c_out, c_oe;
    int          n_fail = 0;
    int          n_checks = 0;
    int          wakes = 0;
    int          starts = 0;
    logic        st, bready, rready;
    logic [3:0]  strb;
    assign pin = d_oe ? d_out : line;
    usart_core dut_u (.i_clock(clk), .i_resetn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(strb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_sleep(sleep),
        .i_receive_data_pin(pin), .o_receive_data_pin_out(d_out),
        .o_receive_data_pin_oe(d_oe), .o_transmit_clock_pin_out(c_out),
        .o_transmit_clock_pin_oe(c_oe), .o_start_bit(st), .o_wake(wk));
    usart_far_end far_u (.i_clock(clk), .i_pol(pol), .i_sck(c_out), .i_sda(d_out),
        .o_line(line));
    always @(posedge clk) if (wk === 1'b1) wakes++;
    always @(posedge clk) if (st === 1'b1) starts++;
    // ========================================
    // bus and compare helpers
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata; r = rresp;
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        rd(OFF_CONTROL); chk("control reset", v, 32'(CONTROL_RESET));
        rd(8'h20); chk("unmapped read", 32'(r), 32'(RESP_SLVERR));
        rd(OFF_TX_DATA); chk("tx data read", 32'(r), 32'(RESP_SLVERR));
        wr(OFF_RX_DATA, 32'h0000_0000); chk("rx data write", 32'(r), 32'(RESP_SLVERR));
        wr(OFF_BAUD, 32'h0000_1234);
        strb <= 4'h1;
        wr(OFF_BAUD, 32'h0000_ff56);
        strb <= 4'hf;
        rd(OFF_BAUD); chk("baud lane mask", v, 32'h0000_1256);
    endtask
    task automatic t_sync(input logic p);
        int b;
        pol <= p;
        wr(OFF_BAUD, 32'h0000_0007);
        wr(OFF_CONTROL, 32'h0000_002f);
        chk("receive mode data oe", 32'(d_oe), 32'h0);
        wr(OFF_CONTROL, {23'h0, p, p, p, 6'h27});
        chk("clock oe", 32'(c_oe), 32'h1);
        chk("clock idle", 32'(c_out), 32'(p));
        chk("data oe", 32'(d_oe), 32'h1);
        @(posedge clk);
        b = far_u.bits_q;
        wr(OFF_TX_DATA, 32'h0000_00a5);
        wr(OFF_TX_DATA, 32'h0000_003c);
        repeat (400) @(posedge clk);
        chk("clock count", 32'(far_u.bits_q - b), p ? 32'd18 : 32'd16);
        chk("second word", 32'(p ? far_u.shift_q : {1'b0, far_u.shift_q[8:1]}),
            {23'h0, p, 8'h3c});
        chk("clock idle after", 32'(c_out), 32'(p));
        wr(OFF_CONTROL, 32'h0000_0000);
    endtask
    task automatic t_wake();
        int w;
        w = wakes;
        rd(OFF_STATUS); chk("idle before wake", 32'(v[ST_RX_IDLE]), 32'h1);
        wr(OFF_CONTROL, 32'h0000_0203);
        far_u.send(13);
        chk("no wake in sync", 32'(wakes - w), 32'h0);
        wr(OFF_CONTROL, 32'h0000_0201);
        sleep <= 1'b1;
        far_u.send(13);
        sleep <= 1'b0;
        chk("wake pulse", 32'(wakes - w), 32'h1);
        rd(OFF_CONTROL); chk("wake self clear", 32'(v[CTL_WAKE_ENABLE]), 32'h0);
        rd(OFF_STATUS); chk("wake flag", 32'(v[ST_RX_FLAG]), 32'h1);
        rd(OFF_RX_DATA); rd(OFF_STATUS);
        chk("wake flag cleared", 32'(v[ST_RX_FLAG]), 32'h0);
    endtask
    task automatic t_abd();
        int s;
        wr(OFF_CONTROL, 32'h0000_0401);
        far_u.send(1);
        repeat (66000) @(posedge clk);
        rd(OFF_STATUS); chk("overflow", 32'(v[2:0]), 32'h5);
        rd(OFF_RX_DATA); rd(OFF_STATUS);
        chk("read clears flag", 32'(v[ST_RX_FLAG]), 32'h0);
        s = starts;
        repeat (4) far_u.send(1);
        chk("no start in measure", 32'(starts - s), 32'h0);
        rd(OFF_STATUS); chk("fifth rise", 32'(v[2:0]), 32'h7);
        rd(OFF_RX_DATA); wr(OFF_STATUS, 32'h0000_0001); rd(OFF_STATUS);
        chk("overflow cleared", 32'(v[2:0]), 32'h2);
        far_u.send(1);
        chk("start after measure", 32'(starts - s), 32'h1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rstn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; sleep = 1'b0; pol = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
        strb = 4'hf; bready = 1'b1; rready = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs(); t_sync(1'b0); t_sync(1'b1); t_wake(); t_abd();
        summarize();
    end
    initial begin
        #900_000;
        n_fail++;
        summarize();
    end
endmodule
